// File: design/gps_params.svh
// Purpose: Shared constants of the ground path safety timer, both link ends.
// Assumes: One 25 MHz clock; PWM and start-up times become cycle counts here.
// Notes:   Long counts are defaults for module parameters so a bench can shorten them.
// What this block does
// - Valid PWM activity leaves idle, starts timers
// - PWM activity stopping returns device to idle
// - Fault cuts switch, pulses notify, enters fault sequence
// - Open-drain active-low notify pulse of 57 ms
// - External power rising edge issues one notify pulse
// - External power level accepted after 10 ms
// - On-time expiry disconnects load, inhibits restart
// - Two three-level pins select on-time prescaler
// - On-time timer counts resistor-set oscillator ticks
// - On-time spans 5-20 s times prescaler
// - Cooldown pin selects 69, 345 or 1380 s
// - Gate drive high only while PWM high, running
// - PWM high phases last at least 40 us
// - Host PWM 4 Hz-5 kHz, duty at least 30%
// - Host waits 3.5 ms before first PWM edge
// - PWM falling edge starts 285 ms gap timer
// - Fault exits after gap expiry, then starts cooldown
// - Cooldown ignores PWM, keeps outputs off, then idle
// - New power event during pulse extends the pulse
`ifndef GPS_PARAMS_SVH
`define GPS_PARAMS_SVH

`define GPS_CLK_NS            40
`define GPS_MS_CYCLES         (1000000 / `GPS_CLK_NS)
`define GPS_PWM_MIN_HI_US     40
`define GPS_PWM_MIN_HI_CYC    ((`GPS_PWM_MIN_HI_US * 1000 + `GPS_CLK_NS - 1) / `GPS_CLK_NS)
`define GPS_NOTIFY_MS         57
`define GPS_DEGLITCH_MS       10
`define GPS_GAP_MS            285
`define GPS_COOL_LOW_S        69
`define GPS_COOL_FLOAT_S      345
`define GPS_COOL_HIGH_S       1380
`define GPS_OSC_MIN_KHZ       100
`define GPS_OSC_MAX_KHZ       400
`define GPS_ONTIME_MIN_S      5
`define GPS_ONTIME_MAX_S      20
`define GPS_ONTIME_BASE_TICKS (`GPS_ONTIME_MIN_S * `GPS_OSC_MAX_KHZ * 1000)
`define GPS_STARTUP_US        3500
`define GPS_STARTUP_CYC       ((`GPS_STARTUP_US * 1000 + `GPS_CLK_NS - 1) / `GPS_CLK_NS)
`define GPS_PWM_FMAX_HZ       5000
`define GPS_PWM_FMIN_HZ       4
`define GPS_PWM_MIN_PER_CYC   ((1000000000 + `GPS_CLK_NS * `GPS_PWM_FMAX_HZ - 1) / (`GPS_CLK_NS * `GPS_PWM_FMAX_HZ))
`define GPS_PWM_MAX_PER_CYC   (1000000000 / (`GPS_CLK_NS * `GPS_PWM_FMIN_HZ))
`define GPS_PWM_MIN_DUTY_PCT  30
`define GPS_PWM_PER_CYC       25000
`define GPS_PWM_HI_CYC        12500

`endif

// File: design/gps_pkg.sv
// Purpose: Types shared by both ends of the safety timer link.
// Assumes: Three-level pins arrive already resolved to a level code.
// Notes:   State codes are Gray along the usual path.
package gps_pkg;

  // Level of a hard-wired three-level pin
  typedef enum logic [1:0] {
    GPS_LVL_LOW   = 2'h0,
    GPS_LVL_FLOAT = 2'h1,
    GPS_LVL_HIGH  = 2'h2
  } gps_lvl_e;

  // Device modes: idle, on, fault, cooling
  typedef enum logic [1:0] {
    GPS_ST_IDLE  = 2'h0,
    GPS_ST_ON    = 2'h1,
    GPS_ST_FAULT = 2'h3,
    GPS_ST_COOL  = 2'h2
  } gps_dev_st_e;

  // Host modes: start-up wait, ready, driving PWM
  typedef enum logic [1:0] {
    GPS_HS_WAIT  = 2'h0,
    GPS_HS_READY = 2'h1,
    GPS_HS_DRIVE = 2'h3
  } gps_host_st_e;

endpackage

// File: design/gps_link_if.sv
// Purpose: Wires between the host and the safety timer device.
// Assumes: The notify line has a pull-up; the device only pulls it low.
// Notes:   The resolved notify level is computed here from the enable.
`timescale 1ns/1ps
interface gps_link_if;
  logic pwm;
  logic notify_out;
  logic notify_oe;
  logic fault_notify_n;

  // Open-drain resolution with pull-up
  assign fault_notify_n = notify_oe ? notify_out : 1'b1;

  modport dev  (input pwm, output notify_out, output notify_oe);
  modport host (output pwm, input fault_notify_n);
endinterface

// File: design/gps_device.sv
// Purpose: Safety timer device end: PWM watch, on-time, gap, cooldown, notify.
// Assumes: Inputs synchronous to clk; ontime_osc_set is a one-cycle tick per oscillator period.
// Notes:   Selection pins are latched on the first edge after reset release.
`timescale 1ns/1ps
`include "gps_params.svh"
module gps_device
  import gps_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = `GPS_MS_CYCLES,
  parameter int unsigned ONTIME_BASE = `GPS_ONTIME_BASE_TICKS,
  parameter int unsigned NOTIFY_CYC  = `GPS_NOTIFY_MS * `GPS_MS_CYCLES,
  parameter int unsigned DEGLITCH_CYC = `GPS_DEGLITCH_MS * `GPS_MS_CYCLES,
  parameter int unsigned GAP_CYC     = `GPS_GAP_MS * `GPS_MS_CYCLES,
  parameter int unsigned MIN_HI_CYC  = `GPS_PWM_MIN_HI_CYC
)(
  input  logic        clk,
  input  logic        sys_rst,
  gps_link_if.dev     link,
  input  logic        ext_power_detect,
  input  gps_lvl_e    ontime_scale_sel_a,
  input  gps_lvl_e    ontime_scale_sel_b,
  input  gps_lvl_e    cooldown_sel,
  input  logic        ontime_osc_set,
  output logic        safety_switch_on,
  output logic        ext_gate_drive,
  output gps_dev_st_e mode
);

  // Prescale factor from the two selection pins
  function automatic logic [10:0] scale_of(input gps_lvl_e a, input gps_lvl_e b);
    logic [10:0] f;
    f = 11'h001;
    if (b == GPS_LVL_LOW) begin
      case (a)
        GPS_LVL_LOW:   f = 11'h001;
        GPS_LVL_FLOAT: f = 11'h004;
        GPS_LVL_HIGH:  f = 11'h010;
        default:       f = 11'h001;
      endcase
    end else if (b == GPS_LVL_HIGH) begin
      case (a)
        GPS_LVL_LOW:   f = 11'h040;
        GPS_LVL_FLOAT: f = 11'h100;
        GPS_LVL_HIGH:  f = 11'h400;
        default:       f = 11'h001;
      endcase
    end
    return f;
  endfunction

  // Cooldown length in ms from the cooldown pin
  function automatic logic [31:0] cool_of(input gps_lvl_e c);
    logic [31:0] m;
    case (c)
      GPS_LVL_FLOAT: m = 32'(`GPS_COOL_FLOAT_S * 1000);
      GPS_LVL_HIGH:  m = 32'(`GPS_COOL_HIGH_S * 1000);
      default:       m = 32'(`GPS_COOL_LOW_S * 1000);
    endcase
    return m;
  endfunction

  logic        cfg_done_r, cfg_done_nxt;
  logic [31:0] ontime_lim_r, ontime_lim_nxt;
  logic [31:0] cool_ms_r, cool_ms_nxt;
  logic [15:0] hi_cnt_r, hi_cnt_nxt;
  gps_dev_st_e state_r, state_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [31:0] ms_r, ms_nxt;
  logic [31:0] ontime_r, ontime_nxt;
  logic        switch_r, switch_nxt;
  logic        gate_r, gate_nxt;
  logic [31:0] dg_cnt_r, dg_cnt_nxt;
  logic        dg_lvl_r, dg_lvl_nxt;
  logic [31:0] notify_r, notify_nxt;
  logic        oe_r, oe_nxt;
  logic        pwm_valid;
  logic        fault_evt;
  logic        power_evt;
  logic        gap_done;

  // Configuration capture, once after reset release
  always_comb begin
    cfg_done_nxt   = 1'b1;
    ontime_lim_nxt = ontime_lim_r;
    cool_ms_nxt    = cool_ms_r;
    if (!cfg_done_r) begin
      ontime_lim_nxt = 32'(ONTIME_BASE) * {21'h0, scale_of(ontime_scale_sel_a, ontime_scale_sel_b)};
      cool_ms_nxt    = cool_of(cooldown_sel);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_done_r   <= 1'b0;
      ontime_lim_r <= 32'h0;
      cool_ms_r    <= 32'h0;
    end else begin
      cfg_done_r   <= cfg_done_nxt;
      ontime_lim_r <= ontime_lim_nxt;
      cool_ms_r    <= cool_ms_nxt;
    end
  end

  // High-phase width filter: a high phase counts once it lasts the minimum width
  always_comb begin
    hi_cnt_nxt = 16'h0;
    if (link.pwm) begin
      hi_cnt_nxt = (hi_cnt_r < 16'(MIN_HI_CYC)) ? hi_cnt_r + 16'h1 : hi_cnt_r;
    end
  end
  assign pwm_valid = link.pwm && (hi_cnt_r >= 16'(MIN_HI_CYC - 1));

  // Gap timer expiry: PWM low for the full gap time
  assign gap_done = !link.pwm && (tmr_r == 32'(GAP_CYC - 1));

  // Mode sequencer with on-time, gap and cooldown timers
  always_comb begin
    state_nxt  = state_r;
    tmr_nxt    = tmr_r;
    ms_nxt     = ms_r;
    ontime_nxt = ontime_r;
    fault_evt  = 1'b0;
    case (state_r)
      GPS_ST_IDLE: begin
        tmr_nxt    = 32'h0;
        ontime_nxt = 32'h0;
        if (cfg_done_r && pwm_valid) begin
          state_nxt = GPS_ST_ON;
        end
      end
      GPS_ST_ON: begin
        tmr_nxt = link.pwm ? 32'h0 : tmr_r + 32'h1;
        if (ontime_osc_set) begin
          ontime_nxt = ontime_r + 32'h1;
        end
        if (ontime_osc_set && (ontime_r >= ontime_lim_r - 32'h1)) begin
          state_nxt = GPS_ST_FAULT;
          fault_evt = 1'b1;
          tmr_nxt   = 32'h0;
        end else if (gap_done) begin
          state_nxt = GPS_ST_IDLE;
        end
      end
      GPS_ST_FAULT: begin
        tmr_nxt = link.pwm ? 32'h0 : tmr_r + 32'h1;
        if (gap_done) begin
          state_nxt = GPS_ST_COOL;
          tmr_nxt   = 32'h0;
          ms_nxt    = 32'h0;
        end
      end
      GPS_ST_COOL: begin
        tmr_nxt = tmr_r + 32'h1; // PWM is not looked at here
        if (tmr_r == 32'(MS_CYCLES - 1)) begin
          tmr_nxt = 32'h0;
          ms_nxt  = ms_r + 32'h1;
          if (ms_r >= cool_ms_r - 32'h1) begin
            state_nxt = GPS_ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = GPS_ST_IDLE;
      end
    endcase
    switch_nxt = (state_nxt == GPS_ST_ON);
    gate_nxt   = (state_nxt == GPS_ST_ON) && link.pwm;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_r <= 16'h0;
      state_r  <= GPS_ST_IDLE;
      tmr_r    <= 32'h0;
      ms_r     <= 32'h0;
      ontime_r <= 32'h0;
      switch_r <= 1'b0;
      gate_r   <= 1'b0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      state_r  <= state_nxt;
      tmr_r    <= tmr_nxt;
      ms_r     <= ms_nxt;
      ontime_r <= ontime_nxt;
      switch_r <= switch_nxt;
      gate_r   <= gate_nxt;
    end
  end

  // External power deglitch and notify pulse timer
  always_comb begin
    dg_cnt_nxt = 32'h0;
    if (ext_power_detect) begin
      dg_cnt_nxt = (dg_cnt_r < 32'(DEGLITCH_CYC)) ? dg_cnt_r + 32'h1 : dg_cnt_r;
    end
    dg_lvl_nxt = ext_power_detect && (dg_cnt_nxt == 32'(DEGLITCH_CYC));
    power_evt  = dg_lvl_nxt && !dg_lvl_r;
    notify_nxt = (notify_r != 32'h0) ? notify_r - 32'h1 : 32'h0;
    if (fault_evt || power_evt) begin
      notify_nxt = 32'(NOTIFY_CYC); // Reload wins over countdown
    end
    oe_nxt = (notify_nxt != 32'h0);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dg_cnt_r <= 32'h0;
      dg_lvl_r <= 1'b0;
      notify_r <= 32'h0;
      oe_r     <= 1'b0;
    end else begin
      dg_cnt_r <= dg_cnt_nxt;
      dg_lvl_r <= dg_lvl_nxt;
      notify_r <= notify_nxt;
      oe_r     <= oe_nxt;
    end
  end

  // Pin drive: open-drain notify only ever pulls low
  assign link.notify_out  = 1'b0;
  assign link.notify_oe   = oe_r;
  assign safety_switch_on = switch_r;
  assign ext_gate_drive   = gate_r;
  assign mode             = state_r;

endmodule

// File: design/gps_host.sv
// Purpose: Host end: waits after start-up, then drives PWM while power is requested.
// Assumes: Inputs synchronous to clk; reset stands for supply becoming valid.
// Notes:   Period and high time are clamped into the legal window.
`timescale 1ns/1ps
`include "gps_params.svh"
module gps_host
  import gps_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = `GPS_STARTUP_CYC,
  parameter int unsigned PERIOD_CYC  = `GPS_PWM_PER_CYC,
  parameter int unsigned HIGH_CYC    = `GPS_PWM_HI_CYC
)(
  input  logic         clk,
  input  logic         sys_rst,
  gps_link_if.host     link,
  input  logic         power_req,
  output logic         ready,
  output logic         notify_low,
  output logic         notify_seen
);

  localparam int unsigned PER_A = (PERIOD_CYC < `GPS_PWM_MIN_PER_CYC) ? `GPS_PWM_MIN_PER_CYC : PERIOD_CYC;
  localparam int unsigned PER   = (PER_A > `GPS_PWM_MAX_PER_CYC) ? `GPS_PWM_MAX_PER_CYC : PER_A;
  localparam int unsigned HI_D  = (PER * `GPS_PWM_MIN_DUTY_PCT + 99) / 100;
  localparam int unsigned HI_A  = (HIGH_CYC < HI_D) ? HI_D : HIGH_CYC;
  localparam int unsigned HI_B  = (HI_A < `GPS_PWM_MIN_HI_CYC) ? `GPS_PWM_MIN_HI_CYC : HI_A;
  localparam int unsigned HI    = (HI_B > PER) ? PER : HI_B;

  gps_host_st_e state_r, state_nxt;
  logic [31:0]  cnt_r, cnt_nxt;
  logic         pwm_r, pwm_nxt;
  logic         nl_r, nl_nxt;
  logic         seen_r, seen_nxt;

  // Start-up wait, then whole PWM periods while requested
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 32'h1;
    case (state_r)
      GPS_HS_WAIT: begin
        if (cnt_r >= 32'(STARTUP_CYC - 1)) begin
          state_nxt = GPS_HS_READY;
          cnt_nxt   = 32'h0;
        end
      end
      GPS_HS_READY: begin
        cnt_nxt = 32'h0;
        if (power_req) begin
          state_nxt = GPS_HS_DRIVE;
        end
      end
      GPS_HS_DRIVE: begin
        if (cnt_r == 32'(PER - 1)) begin
          cnt_nxt = 32'h0;
          if (!power_req) begin
            state_nxt = GPS_HS_READY; // Stop only at a period end
          end
        end
      end
      default: begin
        state_nxt = GPS_HS_WAIT;
        cnt_nxt   = 32'h0;
      end
    endcase
    pwm_nxt  = (state_nxt == GPS_HS_DRIVE) && (cnt_nxt < 32'(HI));
    nl_nxt   = !link.fault_notify_n;
    seen_nxt = nl_nxt && !nl_r;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= GPS_HS_WAIT;
      cnt_r   <= 32'h0;
      pwm_r   <= 1'b0;
      nl_r    <= 1'b0;
      seen_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pwm_r   <= pwm_nxt;
      nl_r    <= nl_nxt;
      seen_r  <= seen_nxt;
    end
  end

  assign link.pwm    = pwm_r;
  assign ready       = (state_r != GPS_HS_WAIT);
  assign notify_low  = nl_r;
  assign notify_seen = seen_r;

endmodule

// File: sim/gps_link_props.sv
// Purpose: Concurrent checks on the host/device link and the device outputs.
// Assumes: One clock; the counts given match the device instance.
// Notes:   Helper counters hold run lengths of pwm, notify drive and power detect.
`timescale 1ns/1ps
module gps_link_props
  import gps_pkg::*;
#(
  parameter int MIN_HI_CYC   = 8,
  parameter int NOTIFY_CYC   = 200,
  parameter int DEGLITCH_CYC = 50,
  parameter int GAP_CYC      = 3000
)(
  input logic        clk,
  input logic        sys_rst,
  input logic        pwm,
  input logic        notify_out,
  input logic        notify_oe,
  input logic        fault_notify_n,
  input logic        ext_power_detect,
  input logic        safety_switch_on,
  input logic        ext_gate_drive,
  input gps_dev_st_e mode
);
  int hi_r, lo_r, oe_r, ext_r;
  int hi_nxt, lo_nxt, oe_nxt, ext_nxt;

  // Run lengths; power detect count saturates so it matches only once
  always_comb begin
    hi_nxt  = pwm ? hi_r + 1 : 0;
    lo_nxt  = pwm ? 0 : lo_r + 1;
    oe_nxt  = notify_oe ? oe_r + 1 : 0;
    ext_nxt = !ext_power_detect ? 0 : (ext_r > DEGLITCH_CYC) ? ext_r : ext_r + 1;
  end

  // Counter registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {hi_r, lo_r, oe_r, ext_r} <= '0;
    end else begin
      {hi_r, lo_r, oe_r, ext_r} <= {hi_nxt, lo_nxt, oe_nxt, ext_nxt};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_notify_pulls_low: assert property (notify_oe |-> !notify_out && !fault_notify_n)
    else $error("notify enabled but line not low");
  chk_notify_min_len: assert property ($fell(notify_oe) |-> oe_r >= NOTIFY_CYC)
    else $error("notify pulse too short");
  chk_fault_entry_cuts: assert property (mode == GPS_ST_FAULT && $past(mode) != GPS_ST_FAULT
    |-> notify_oe && !safety_switch_on && !ext_gate_drive)
    else $error("fault entry without cut or pulse");
  chk_outputs_off_idle: assert property (mode != GPS_ST_ON |-> !safety_switch_on && !ext_gate_drive)
    else $error("switch or gate on outside on mode");
  chk_gate_follows_pwm: assert property (mode == GPS_ST_ON |-> ext_gate_drive == $past(pwm))
    else $error("gate drive not following pwm");
  chk_power_event_pulse: assert property (ext_r == DEGLITCH_CYC |-> notify_oe)
    else $error("no pulse after power detect");
  chk_pulse_has_cause: assert property ($rose(notify_oe) |-> ext_r == DEGLITCH_CYC || mode == GPS_ST_FAULT)
    else $error("pulse without accepted cause");
  chk_on_needs_width: assert property (mode == GPS_ST_ON && $past(mode) == GPS_ST_IDLE
    |-> hi_r >= MIN_HI_CYC && safety_switch_on)
    else $error("on entry without valid pwm high");
  chk_idle_after_gap: assert property (mode == GPS_ST_IDLE && $past(mode) == GPS_ST_ON |-> lo_r >= GAP_CYC)
    else $error("idle entered before gap expiry");
  chk_cool_after_gap: assert property (mode == GPS_ST_COOL && $past(mode) == GPS_ST_FAULT |-> lo_r >= GAP_CYC)
    else $error("cooldown entered before gap expiry");

  // Main scenarios reached
  cov_fault: cover property ($changed(mode) && mode == GPS_ST_FAULT);
  cov_cool_done: cover property ($past(mode) == GPS_ST_COOL && mode == GPS_ST_IDLE);
  cov_extend: cover property (ext_r == DEGLITCH_CYC && $past(notify_oe));
endmodule

// File: sim/testbench.sv
// Purpose: Self-checking bench joining host and device over the link.
// Assumes: Shortened counts; cooldown pin low so one cooling window fits the run.
// Notes:   Oscillator ticks every fourth cycle while enabled.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
  import gps_pkg::*;
  localparam int NTF  = 200;
  localparam int DEG  = 50;
  localparam int GAP  = 3000;
  localparam int OTB  = 20;
  localparam int MINH = 8;
  localparam int COOL = 69000;
  logic        clk, sys_rst, power_req, ext_power_detect, ontime_osc_set, osc_en;
  logic        safety_switch_on, ext_gate_drive, ready, notify_low, notify_seen;
  gps_lvl_e    sel_a;
  gps_dev_st_e mode;
  int          num_errors = 0, checks_done = 0, cyc = 0, n;

  gps_link_if gps_link_if_i ();
  gps_device #(.MS_CYCLES(1), .ONTIME_BASE(OTB), .NOTIFY_CYC(NTF), .DEGLITCH_CYC(DEG), .GAP_CYC(GAP),
    .MIN_HI_CYC(MINH)) gps_device_i (.clk(clk), .sys_rst(sys_rst), .link(gps_link_if_i),
    .ext_power_detect(ext_power_detect), .ontime_scale_sel_a(sel_a), .ontime_scale_sel_b(GPS_LVL_LOW),
    .cooldown_sel(GPS_LVL_LOW), .ontime_osc_set(ontime_osc_set), .safety_switch_on(safety_switch_on),
    .ext_gate_drive(ext_gate_drive), .mode(mode));
  gps_host #(.STARTUP_CYC(20), .PERIOD_CYC(5000), .HIGH_CYC(2500)) gps_host_i (.clk(clk), .sys_rst(sys_rst),
    .link(gps_link_if_i), .power_req(power_req), .ready(ready), .notify_low(notify_low), .notify_seen(notify_seen));
  gps_link_props #(.MIN_HI_CYC(MINH), .NOTIFY_CYC(NTF), .DEGLITCH_CYC(DEG), .GAP_CYC(GAP)) gps_link_props_i (
    .clk(clk), .sys_rst(sys_rst), .pwm(gps_link_if_i.pwm), .notify_out(gps_link_if_i.notify_out),
    .notify_oe(gps_link_if_i.notify_oe), .fault_notify_n(gps_link_if_i.fault_notify_n),
    .ext_power_detect(ext_power_detect), .safety_switch_on(safety_switch_on), .ext_gate_drive(ext_gate_drive),
    .mode(mode));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Oscillator ticks and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ontime_osc_set <= osc_en && (cyc % 4 == 0);
    if (cyc == 99000) begin
      num_errors++;
      test_done();
    end
  end

  // Wait for a device mode; n gives the cycles taken
  task automatic wait_mode(input gps_dev_st_e m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(mode, m)
  endtask

  // Wait for a notify line level; n gives the cycles taken
  task automatic wait_ntf(input logic lvl, input int lim);
    n = 0;
    while (gps_link_if_i.fault_notify_n !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(gps_link_if_i.fault_notify_n, lvl)
  endtask

  // Main sequence: normal cycle, fault and cooldown, power detect, second reset
  initial begin
    {sys_rst, power_req, ext_power_detect, osc_en} = 4'h8;
    sel_a = GPS_LVL_LOW;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    `CHK(mode, GPS_ST_IDLE)
    `CHK(gps_link_if_i.fault_notify_n, 1'b1)
    `CHK(ready, 1'b1)
    @(posedge clk) power_req <= 1'b1;
    wait_mode(GPS_ST_ON, 100);
    `CHK(n >= MINH && n <= MINH + 5, 1'b1)
    `CHK(safety_switch_on, 1'b1)
    `CHK(ext_gate_drive, 1'b1)
    while (gps_link_if_i.pwm !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    `CHK(ext_gate_drive, 1'b0)
    `CHK(safety_switch_on, 1'b1)
    repeat (3000) @(posedge clk);
    #1;
    `CHK(mode, GPS_ST_ON)
    @(posedge clk) power_req <= 1'b0;
    wait_mode(GPS_ST_IDLE, 10000);
    `CHK(safety_switch_on, 1'b0)
    @(posedge clk) begin
      osc_en <= 1'b1;
      power_req <= 1'b1;
    end
    wait_mode(GPS_ST_ON, 6000);
    wait_mode(GPS_ST_FAULT, 100);
    `CHK(n >= 4 * OTB - 4 && n <= 4 * OTB + 4, 1'b1)
    `CHK(gps_link_if_i.fault_notify_n, 1'b0)
    `CHK(safety_switch_on | ext_gate_drive, 1'b0)
    @(posedge clk);
    #1;
    `CHK(notify_low, 1'b1)
    `CHK(notify_seen, 1'b1)
    wait_ntf(1'b1, NTF + 10);
    `CHK(n >= NTF - 1 && n <= NTF + 1, 1'b1)
    `CHK(mode, GPS_ST_FAULT)
    @(posedge clk) power_req <= 1'b0;
    wait_mode(GPS_ST_COOL, 10000);
    @(posedge clk) begin
      power_req <= 1'b1;
      osc_en <= 1'b0;
    end
    wait_mode(GPS_ST_IDLE, COOL + 10);
    `CHK(n >= COOL - 2 && n <= COOL, 1'b1)
    wait_mode(GPS_ST_ON, 6000);
    @(posedge clk) power_req <= 1'b0;
    ext_power_detect <= 1'b1;
    repeat (DEG - 10) @(posedge clk);
    ext_power_detect <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK(gps_link_if_i.fault_notify_n, 1'b1)
    @(posedge clk) ext_power_detect <= 1'b1;
    wait_ntf(1'b0, DEG + 10);
    `CHK(n >= DEG - 1 && n <= DEG + 2, 1'b1)
    repeat (20) @(posedge clk);
    ext_power_detect <= 1'b0;
    repeat (10) @(posedge clk);
    ext_power_detect <= 1'b1;
    wait_ntf(1'b1, NTF + DEG + 20);
    `CHK(n >= NTF + DEG - 3 && n <= NTF + DEG + 2, 1'b1)
    repeat (300) @(posedge clk);
    #1;
    `CHK(gps_link_if_i.fault_notify_n, 1'b1)
    @(posedge clk) begin
      sys_rst <= 1'b1;
      ext_power_detect <= 1'b0;
      sel_a <= GPS_LVL_FLOAT;
      osc_en <= 1'b1;
    end
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clk);
    sel_a <= GPS_LVL_HIGH;
    power_req <= 1'b1;
    wait_mode(GPS_ST_ON, 100);
    wait_mode(GPS_ST_FAULT, 400);
    `CHK(n >= 16 * OTB - 4 && n <= 16 * OTB + 4, 1'b1)
    test_done();
  end
endmodule
